/* rtl/dscr_defines.svh */
// Constants of the serial DAC command decoder: frame layout, codes and reset values.
// Assumes inclusion by bare name from the package and from dscr_serial_regs.
`ifndef DSCR_DEFINES_SVH
`define DSCR_DEFINES_SVH

`define DSCR_FRAME_BITS 16
`define DSCR_RW_POS 15
`define DSCR_SEL_HI 14
`define DSCR_SEL_LO 12
`define DSCR_DATA_BITS 12
`define DSCR_SEL_NOP 3'h0
`define DSCR_SEL_DAC 3'h1
`define DSCR_SEL_CTL 3'h7
`define DSCR_CTL_BITS 7
`define DSCR_CTL_OVERTEMP 0
`define DSCR_CTL_POWERUP 2
`define DSCR_CTL_FLOAT 6
`define DSCR_CTL_RESET 7'h40
`define DSCR_DAC_RESET 12'h000
`define DSCR_RD_DRIVE_EDGE 5
`define DSCR_RD_FIRST_FALL 4

`endif

/* rtl/dscr_pkg.sv */
// Types shared by the serial DAC command decoder.
// Assumes dscr_defines.svh is on the include path.
`include "dscr_defines.svh"

package dscr_pkg;
    typedef enum logic [1:0] {
        DSCR_IDLE,
        DSCR_SHIFT,
        DSCR_DONE
    } dscr_state_e;

    typedef logic [`DSCR_FRAME_BITS-1:0] dscr_frame_t;
    typedef logic [`DSCR_CTL_BITS-1:0] dscr_ctl_t;
endpackage : dscr_pkg

/* rtl/dscr_pin_sync.sv */
// Two-flop synchroniser bank for pins coming from the host's clock-free world.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/10ps
`default_nettype none

module dscr_pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk_sys,              // System clock.
    input wire logic sys_rst,              // Synchronous reset, active high.
    input wire logic [WIDTH-1:0] pin_in,   // Raw pin levels.
    input wire logic [WIDTH-1:0] rst_val,  // Constant idle levels for reset.
    output logic [WIDTH-1:0] pin_sync      // Synchronised levels.
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_r <= rst_val;
            pin_sync <= rst_val;
        end else begin
            meta_r <= pin_in;
            pin_sync <= meta_r;
        end
    end
endmodule : dscr_pin_sync

`default_nettype wire

/* rtl/dscr_serial_regs.sv */
// Serial command decoder and register set of a single-channel 12-bit DAC.
// Assumes serial clock, frame select and serial data come from a host, are
// asynchronous, and toggle far slower than clk_sys (serial clock at most clk_sys/8).
//
// Overview of operation
// - Select code all ones in bits 14..12 writes the control register.
// - Frame: bit 15 read/write, bits 14..12 select, bits 11..0 data.
// - Select 000 no-op, 001 DAC input, 111 control, others reserved.
// - Control write: bits 11..7 zero, bits 6, 2 and 0 carry the three control fields.
// - Control bit zero reads one while thermal shutdown is active.
// - Control bit two powers the channel up; cleared powered-down is default.
// - Bit six cleared ties a powered-down output to ground through resistor.
// - Bit six set leaves the output high-impedance; this is the default.
// - Control register contents set the output power-up state.
// - Read frame shifts register out on the final 12 serial clocks.
// - Data sampled on rising edges, MSB first; action on 16th falling edge.
// - Thermal flag stays set, alarm low, until the host clears it.
// - Data output high-impedance until fifth rising edge; released at end or frame end.
`include "dscr_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module dscr_serial_regs
    import dscr_pkg::*;
(
    input wire logic clk_sys,                    // System clock, 100 MHz.
    input wire logic sys_rst,                    // Synchronous reset, active high.
    input wire logic sclk_pin,                   // Serial clock from host.
    input wire logic frame_sel_n_pin,            // Frame select, active low.
    input wire logic sdi_pin,                    // Serial data in.
    input wire logic load_strobe_n,              // Load strobe, active low (async pin).
    input wire logic overtemp_event,             // Die over-temperature level, same clock.
    output logic sdo_o,                          // Serial data out value.
    output logic sdo_oe,                         // Serial data out drive enable.
    output logic [`DSCR_DATA_BITS-1:0] dac_code, // Code applied to the converter.
    output logic channel_powerup,                // Analog channel powered.
    output logic output_float_sel,               // Powered-down output floats when high.
    output logic output_to_ground,               // Ground the output through resistor.
    output logic alarm_n                         // Thermal alarm, active low.
);
    typedef struct packed {
        dscr_state_e state;
        logic sclk_d;
        logic strobe_d;
        logic [4:0] rise_cnt;
        logic [4:0] fall_cnt;
        dscr_frame_t shift;
        logic is_read;
        logic [`DSCR_DATA_BITS-1:0] rd_data;
        logic sdo;
        logic sdo_oe;
        logic [`DSCR_DATA_BITS-1:0] dac_input;
        logic [`DSCR_DATA_BITS-1:0] dac_reg;
        dscr_ctl_t ctl;
        logic sync_load;
    } dscr_regs_s;

    dscr_regs_s st_r;
    dscr_regs_s st_nxt;
    logic [3:0] pins_s;
    logic sclk_s;
    logic fsel_n_s;
    logic sdi_s;
    logic strobe_n_s;
    logic sclk_rise;
    logic sclk_fall;
    logic strobe_fall;
    logic [2:0] sel;
    dscr_frame_t frame_full;

    dscr_pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .pin_in({load_strobe_n, sdi_pin, frame_sel_n_pin, sclk_pin}),
        .rst_val(4'ha), // Idle levels: strobe high, data low, frame select high, clock low.
        .pin_sync(pins_s)
    );

    assign sclk_s = pins_s[0];
    assign fsel_n_s = pins_s[1];
    assign sdi_s = pins_s[2];
    assign strobe_n_s = pins_s[3];
    assign sclk_rise = sclk_s && !st_r.sclk_d;
    assign sclk_fall = !sclk_s && st_r.sclk_d;
    assign strobe_fall = !strobe_n_s && st_r.strobe_d;
    assign frame_full = st_r.shift;
    assign sel = frame_full[`DSCR_SEL_HI:`DSCR_SEL_LO];

    always_comb begin
        st_nxt = st_r;
        st_nxt.sclk_d = sclk_s;
        st_nxt.strobe_d = strobe_n_s;

        // Over-temperature sets the flag and shuts the channel down; the flag holds
        // until the host clears it. The set is applied last so it wins a clear.
        case (st_r.state)
            DSCR_IDLE: begin
                st_nxt.sdo_oe = 1'b0;
                if (!fsel_n_s) begin
                    st_nxt.state = DSCR_SHIFT;
                    st_nxt.rise_cnt = 5'h0;
                    st_nxt.fall_cnt = 5'h0;
                    st_nxt.is_read = 1'b0;
                end
            end
            DSCR_SHIFT: begin
                if (fsel_n_s) begin
                    // Frame aborted early: nothing executes, output released.
                    st_nxt.state = DSCR_IDLE;
                    st_nxt.sdo_oe = 1'b0;
                end else begin
                    if (sclk_rise) begin
                        st_nxt.shift = {st_r.shift[`DSCR_FRAME_BITS-2:0], sdi_s};
                        st_nxt.rise_cnt = st_r.rise_cnt + 5'h1;
                        if (st_r.rise_cnt == 5'(`DSCR_RD_FIRST_FALL - 1)) begin
                            // Fourth rising edge: the read flag already sits in bit two, so it
                            // is known in time to enable the output on the fifth rise.
                            st_nxt.is_read = st_r.shift[2];
                        end
                        if (st_r.rise_cnt == 5'(`DSCR_RD_DRIVE_EDGE - 1) && st_r.is_read) begin
                            st_nxt.sdo_oe = 1'b1;
                        end
                    end
                    if (sclk_fall) begin
                        st_nxt.fall_cnt = st_r.fall_cnt + 5'h1;
                        if (st_r.fall_cnt == 5'(`DSCR_RD_FIRST_FALL - 1) && st_r.is_read) begin
                            // Header known: latch readback word and present its MSB.
                            // Only four bits are in yet, so the select code is in bits 2..0.
                            case (st_r.shift[`DSCR_SEL_HI-`DSCR_SEL_LO:0])
                                `DSCR_SEL_DAC: st_nxt.rd_data = st_r.dac_input;
                                `DSCR_SEL_CTL: st_nxt.rd_data = {5'h0, st_r.ctl};
                                default: st_nxt.rd_data = `DSCR_DAC_RESET;
                            endcase
                            st_nxt.sdo = st_nxt.rd_data[`DSCR_DATA_BITS-1];
                        end else if (st_r.fall_cnt >= 5'(`DSCR_RD_FIRST_FALL)
                                     && st_r.fall_cnt < 5'(`DSCR_FRAME_BITS - 1)) begin
                            // Shift the remaining 11 bits out on falling edges 5 to 15.
                            st_nxt.rd_data = {st_r.rd_data[`DSCR_DATA_BITS-2:0], 1'b0};
                            st_nxt.sdo = st_r.rd_data[`DSCR_DATA_BITS-2];
                        end
                        if (st_r.fall_cnt == 5'(`DSCR_FRAME_BITS - 1)) begin
                            // Sixteenth falling edge: execute the frame.
                            st_nxt.state = DSCR_DONE;
                            st_nxt.sdo_oe = 1'b0;
                            if (!st_r.shift[`DSCR_RW_POS]) begin
                                if (sel == `DSCR_SEL_DAC) begin
                                    st_nxt.dac_input = st_r.shift[`DSCR_DATA_BITS-1:0];
                                    // Low strobe at this edge loads the DAC on the next clk_sys cycle.
                                    st_nxt.sync_load = !strobe_n_s;
                                end else if (sel == `DSCR_SEL_CTL) begin
                                    // Reserved bits 11..7, 5..3, 1 are dropped
                                    st_nxt.ctl[`DSCR_CTL_POWERUP] =
                                        st_r.shift[`DSCR_CTL_POWERUP];
                                    st_nxt.ctl[`DSCR_CTL_FLOAT] =
                                        st_r.shift[`DSCR_CTL_FLOAT];
                                    // Writing zero clears the sticky flag; one is ignored.
                                    if (!st_r.shift[`DSCR_CTL_OVERTEMP]) begin
                                        st_nxt.ctl[`DSCR_CTL_OVERTEMP] = 1'b0;
                                    end
                                end
                                // No-op and reserved codes fall through untouched
                            end
                        end
                    end
                end
            end
            DSCR_DONE: begin
                // Wait for frame select to rise before a new frame can start.
                st_nxt.sdo_oe = 1'b0;
                if (fsel_n_s) begin
                    st_nxt.state = DSCR_IDLE;
                end
            end
            default: st_nxt.state = DSCR_IDLE;
        endcase

        if (st_r.sync_load) begin
            st_nxt.dac_reg = st_r.dac_input;
            st_nxt.sync_load = 1'b0;
        end else if (strobe_fall) begin
            st_nxt.dac_reg = st_nxt.dac_input;
        end

        if (overtemp_event) begin
            st_nxt.ctl[`DSCR_CTL_OVERTEMP] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.state <= DSCR_IDLE;
            st_r.sclk_d <= 1'b0;
            st_r.strobe_d <= 1'b1;
            st_r.ctl <= `DSCR_CTL_RESET;
            st_r.dac_input <= `DSCR_DAC_RESET;
            st_r.dac_reg <= `DSCR_DAC_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sdo_o = st_r.sdo;
    assign sdo_oe = st_r.sdo_oe;
    assign dac_code = st_r.dac_reg;
    assign alarm_n = !st_r.ctl[`DSCR_CTL_OVERTEMP];
    // Thermal shutdown acts like clearing the power-up bit
    assign channel_powerup = st_r.ctl[`DSCR_CTL_POWERUP] && !st_r.ctl[`DSCR_CTL_OVERTEMP];
    assign output_float_sel = st_r.ctl[`DSCR_CTL_FLOAT];
    assign output_to_ground = !channel_powerup && !st_r.ctl[`DSCR_CTL_FLOAT];
endmodule : dscr_serial_regs

`default_nettype wire

/* sim/dscr_serial_regs_checker.sv */
// Port assertions for the serial DAC command decoder.
// Assumes binding to dscr_serial_regs and slow host pins (serial clock of 160 ns).
`timescale 1ns/10ps
`default_nettype none

module dscr_serial_regs_checker (
    input wire logic clk_sys, sys_rst, sclk_pin, frame_sel_n_pin, sdi_pin, // Inputs.
    input wire logic load_strobe_n, overtemp_event, sdo_o, sdo_oe, // Pins.
    input wire logic [11:0] dac_code, // Converter code.
    input wire logic channel_powerup, output_float_sel, output_to_ground, alarm_n // Outputs.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_reset_state: assert property (disable iff (1'b0)
        sys_rst |=> output_float_sel && !channel_powerup && alarm_n && !sdo_oe && dac_code == 0)
        else $error("Outputs wrong after reset.");
    a_alarm_set: assert property (overtemp_event |=> !alarm_n)
        else $error("Alarm not raised by over-temperature.");
    // Eight idle cycles let any pending control write land before stickiness is judged.
    a_flag_sticky: assert property (frame_sel_n_pin [*8] ##0 !alarm_n |=> !alarm_n)
        else $error("Thermal flag cleared without a write.");
    a_power_gate: assert property (!alarm_n |-> !channel_powerup)
        else $error("Channel powered during thermal shutdown.");
    a_ground_map: assert property (
        output_to_ground == (!channel_powerup && !output_float_sel))
        else $error("Output grounding does not follow control.");
    a_sdo_idle: assert property (frame_sel_n_pin [*8] |-> !sdo_oe)
        else $error("Serial out driven outside a frame.");
    a_sdo_start: assert property ($rose(sdo_oe) |-> $past(sclk_pin, 2) && !frame_sel_n_pin)
        else $error("Serial out enabled away from a clock rise.");
    a_code_hold: assert property (
        frame_sel_n_pin [*8] ##0 load_strobe_n [*8] |=> $stable(dac_code))
        else $error("Converter code changed with no cause.");

    cover property (!alarm_n);
    cover property ($rose(sdo_oe));
    cover property (output_to_ground);
endmodule : dscr_serial_regs_checker

bind dscr_serial_regs dscr_serial_regs_checker dscr_serial_regs_checker_i (.*);
`default_nettype wire

/* sim/dscr_host_model.sv */
// Host serial master model that drives frames into the DAC decoder.
// Assumes clk_sys at 100 MHz; the serial clock stands low between frames.
`timescale 1ns/10ps
`default_nettype none

module dscr_host_model (
    input wire logic clk_sys, // Bench clock.
    output logic sclk = 1'b0, // Serial clock, 160 ns period.
    output logic fsel_n = 1'b1, // Frame select, active low.
    output logic sdi = 1'b0, // Serial data to the device.
    input wire logic sdo, // Serial data from the device.
    input wire logic sdo_oe // Device drives sdo when high.
);
    task automatic half();
        repeat (8) @(posedge clk_sys);
    endtask : half

    // Sends the first nb bits MSB first; fewer than 16 aborts the frame.
    task automatic xfer(input logic [15:0] w, input int nb, output logic [11:0] rd);
        rd = 12'hxxx;
        fsel_n <= 1'b0;
        for (int i = 15; i >= 16 - nb; i--) begin
            sdi <= w[i];
            half();
            sclk <= 1'b1;
            half();
            // Captured at the end of the high phase, where the synchronised output stands.
            if (i < 12) rd[i] = sdo_oe ? sdo : 1'bx;
            sclk <= 1'b0;
        end
        half();
        fsel_n <= 1'b1;
        // The released line shows the inverse, so a stale bit is never mistaken for data.
        sdi <= ~sdi;
        half();
    endtask : xfer
endmodule : dscr_host_model
`default_nettype wire

/* sim/dac_serial_control_regs_tb.sv */
// Self-checking bench of the serial DAC command decoder.
// Assumes the host model drives the serial pins and the checker binds itself.
`timescale 1ns/10ps
`default_nettype none

module dac_serial_control_regs_tb;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic load_strobe_n = 1'b1;
    logic overtemp_event = 1'b0;
    logic sclk, fsel_n, sdi, sdo_o, sdo_oe, channel_powerup, output_float_sel;
    logic output_to_ground, alarm_n;
    logic [11:0] dac_code, rd;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;

    dscr_serial_regs dscr_serial_regs_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk_pin(sclk),
        .frame_sel_n_pin(fsel_n), .sdi_pin(sdi), .load_strobe_n(load_strobe_n),
        .overtemp_event(overtemp_event), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .dac_code(dac_code),
        .channel_powerup(channel_powerup), .output_float_sel(output_float_sel),
        .output_to_ground(output_to_ground), .alarm_n(alarm_n));
    dscr_host_model dscr_host_model_i (.clk_sys(clk_sys), .sclk(sclk), .fsel_n(fsel_n),
        .sdi(sdi), .sdo(sdo_o), .sdo_oe(sdo_oe));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // About twenty-five frames of some 300 cycles each fit well inside this ceiling.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            conclude();
        end
    end

    task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] w);
        dscr_host_model_i.xfer(w, 16, rd);
    endtask : wr

    task automatic rdb(input logic [2:0] s, input logic [11:0] exp);
        dscr_host_model_i.xfer({1'b1, s, 12'h000}, 16, rd);
        chk(rd, exp);
    endtask : rdb

    task automatic t_dac();
        load_strobe_n <= 1'b0;
        wr(16'h1A5C);
        chk(dac_code, 12'hA5C);
        rdb(3'h1, 12'hA5C);
        load_strobe_n <= 1'b1;
        wr(16'h13C3);
        chk(dac_code, 12'hA5C);
        rdb(3'h1, 12'h3C3);
        load_strobe_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(dac_code, 12'h3C3);
    endtask : t_dac

    task automatic t_ctl();
        wr(16'h7004);
        wr(16'h0000);
        chk(channel_powerup, 1'b1);
        chk(output_float_sel, 1'b0);
        rdb(3'h7, 12'h004);
        wr(16'h7000);
        wr(16'h0000);
        chk(output_to_ground, 1'b1);
        wr(16'h7040);
        wr(16'h0000);
        chk(output_to_ground, 1'b0);
    endtask : t_ctl

    task automatic t_refuse();
        for (int s = 0; s < 7; s++) begin
            if (s != 1) wr({1'b0, 3'(s), 12'hFFF});
        end
        dscr_host_model_i.xfer(16'h1FFF, 8, rd);
        rdb(3'h1, 12'h3C3);
        rdb(3'h7, 12'h040);
        rdb(3'h3, 12'h000);
    endtask : t_refuse

    task automatic t_thermal();
        wr(16'h7044);
        wr(16'h0000);
        overtemp_event <= 1'b1;
        @(posedge clk_sys);
        overtemp_event <= 1'b0;
        rdb(3'h7, 12'h045);
        chk(alarm_n, 1'b0);
        chk(channel_powerup, 1'b0);
        wr(16'h7044);
        wr(16'h0000);
        chk(alarm_n, 1'b1);
        chk(channel_powerup, 1'b1);
    endtask : t_thermal

    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(output_float_sel, 1'b1);
        rdb(3'h7, 12'h040);
        t_dac();
        t_ctl();
        t_refuse();
        t_thermal();
        conclude();
    end
endmodule : dac_serial_control_regs_tb
`default_nettype wire
